// ### rtl/bfs_pkg.sv
// Purpose: constants and types of the ballast fault supervisor
// Assumes: 100 MHz hclk
// Notes: times kept in printed units; 1us, 5us and 10us window counts derived here, the rest in the module
package bfs_pkg;
   localparam longint CLK_NS = 10;
   // Filter, window, mode and wait times
   localparam longint T_START_US = 1;
   localparam longint T_LOCK_US = 5;
   localparam longint T_PU_WIN_US = 10;
   localparam longint T_FIL_US = 100;
   localparam longint T_F620_US = 620;
   localparam longint T_UV_US = 84;
   localparam longint T_UV_ADD_US = 120;
   localparam longint T_PU_US = 130;
   localparam longint T_SOFT_MS = 10;
   localparam longint T_PH_MS = 2500;
   localparam longint T_IGN_MIN_MS = 40;
   localparam longint T_IGN_MAX_MS = 237;
   localparam longint T_PRE_MS = 625;
   localparam longint T_BUS_MS = 625;
   localparam longint T_STO_MS = 80;
   localparam longint T_WAIT_F_MS = 200;
   localparam longint T_WAIT_UV_MS = 100;
   localparam longint T_RECT_MS = 2500;
   localparam longint T_CLR_S = 40;
   localparam logic [31:0] C1US = 32'(T_START_US * 1000 / CLK_NS);
   localparam logic [31:0] C5US = 32'(T_LOCK_US * 1000 / CLK_NS);
   localparam logic [31:0] CWIN = 32'(T_PU_WIN_US * 1000 / CLK_NS);
   localparam logic [2:0] UV_MAX = 3'h7;
   localparam int NCH = 15;
   localparam int NEV = 17;
   // Operating states, one-hot
   typedef enum logic [11:0] {
      BFS_MON = 12'h001, BFS_PU = 12'h002, BFS_SU = 12'h004,
      BFS_SOFT = 12'h008, BFS_PH = 12'h010, BFS_IGN = 12'h020,
      BFS_PRE = 12'h040, BFS_RUN = 12'h080, BFS_RWAIT = 12'h100,
      BFS_CWAIT = 12'h200, BFS_VWAIT = 12'h400, BFS_LATCH = 12'h800
   } bfs_state_t;
   localparam logic [11:0] M_ALL = 12'hfff;
   localparam logic [11:0] M_ACT = 12'h0fc;
   // Comparator results, high while the condition holds
   typedef struct packed {
      logic supply_below_start;
      logic supply_below_lockout;
      logic hs_filament_sense_a;
      logic hs_filament_sense_b;
      logic ls_filament_sense_open;
      logic ls_filament_sense_high;
      logic boost_bus_below_open;
      logic boost_bus_below_under;
      logic boost_bus_below_rated;
      logic boost_bus_above_high;
      logic boost_bus_above_over;
      logic lamp_peak_overvoltage;
      logic lamp_rectifier_effect;
   } bfs_comp_t;
   // Register map
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_STAT = 8'h04;
   localparam logic [7:0] A_IRQ_ST = 8'h08;
   localparam logic [7:0] A_IRQ_CLR = 8'h0c;
   localparam logic [7:0] A_IRQ_EN = 8'h10;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
endpackage

// ### rtl/bfs_supervisor.sv
// Purpose: fault supervisor and mode sequencer of a lamp ballast controller
// Assumes: comparators digitised outside; hresetn is the supply lockout reset
// Notes: registers over AHB-Lite, zero wait states, always OKAY
// Notes on behaviour
// - Monitoring: supply below start threshold blocks power-up at once, without the 1us filter.
// - Supply below lockout 5us in any mode powers down, clears fail latch.
// - Monitoring: either high-side filament current low 100us blocks power-up.
// - Monitoring: low-side filament sense above 1.6V 100us blocks power-up.
// - Run: low-side sense above 3.2V 620us gives single-restart fault.
// - Power-up: bus below 12.5% after 10us, 1us, keeps gates off.
// - Start-up to run: bus below 12.5% 1us stops PFC until it recovers.
// - Run: bus below 12.5% 625ms shuts down, restart when bus recovers.
// - Run: bus below 75% 84us plus 120us, wait 100ms, restart, max seven.
// - Bus under 95% after 80ms of start-up: power down, wait 200ms.
// - Power-up: bus above 105% after 10us, 5us, keeps gates off.
// - Bus above 109% 5us stops PFC until bus below 105%.
// - Run: bus above 109% 625ms shuts down, restart below 105%.
// - Run: lamp peak overvoltage 620us gives single-restart fault.
// - Run: lamp rectifier effect 2500ms gives single-restart fault.
// - Preheat and ignition end early on preheat_done or ignition_done, start-up at 95% bus, other mode durations fixed; each check enabled only in its modes.
// - Single-restart fault waits 200ms and restarts; second one latches off.
// - Fail latch cleared by supply lockout or 40s of run.
//
// Implementation choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none
module bfs_supervisor
   import bfs_pkg::*;
#(
   parameter longint unsigned FIL_CYC = T_FIL_US * 1000 / CLK_NS,
   parameter longint unsigned F620_CYC = T_F620_US * 1000 / CLK_NS,
   parameter longint unsigned UV_CYC = (T_UV_US + T_UV_ADD_US) * 1000 / CLK_NS,
   parameter longint unsigned PU_CYC = T_PU_US * 1000 / CLK_NS,
   parameter longint unsigned SOFT_CYC = T_SOFT_MS * 1000000 / CLK_NS,
   parameter longint unsigned PH_CYC = T_PH_MS * 1000000 / CLK_NS,
   parameter longint unsigned IGN_MIN_CYC = T_IGN_MIN_MS * 1000000 / CLK_NS,
   parameter longint unsigned IGN_MAX_CYC = T_IGN_MAX_MS * 1000000 / CLK_NS,
   parameter longint unsigned PRE_CYC = T_PRE_MS * 1000000 / CLK_NS,
   parameter longint unsigned BUS_CYC = T_BUS_MS * 1000000 / CLK_NS,
   parameter longint unsigned STO_CYC = T_STO_MS * 1000000 / CLK_NS,
   parameter longint unsigned WAIT_F_CYC = T_WAIT_F_MS * 1000000 / CLK_NS,
   parameter longint unsigned WAIT_UV_CYC = T_WAIT_UV_MS * 1000000 / CLK_NS,
   parameter longint unsigned RECT_CYC = T_RECT_MS * 1000000 / CLK_NS,
   parameter longint unsigned CLR_CYC = T_CLR_S * 1000000000 / CLK_NS
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire bfs_pkg::bfs_comp_t comp_in,
   input wire logic preheat_done,
   input wire logic ignition_done,
   output logic gate_enable,
   output logic pfc_enable,
   output logic irq
);
   // Clear count fits 32 bits; power-up must leave room for its 5us bus filter
   if (CLR_CYC > 64'hffff_ffff || FIL_CYC < 1 || F620_CYC < 1 || UV_CYC < 1 ||
       PU_CYC <= CWIN + C5US || SOFT_CYC < 1 || PH_CYC < 1 || IGN_MIN_CYC < 1 ||
       IGN_MAX_CYC <= IGN_MIN_CYC || PRE_CYC < 1 || BUS_CYC < 1 ||
       STO_CYC < 1 || WAIT_F_CYC < 1 || WAIT_UV_CYC < 1 || RECT_CYC < 1 ||
       CLR_CYC < 1) begin : g_bad_param
      $error("bfs_supervisor: timing parameter out of range");
   end

   localparam logic [31:0] FLEN [NCH] = '{
      C1US, C5US, 32'(FIL_CYC), 32'(FIL_CYC), 32'(FIL_CYC), 32'(F620_CYC),
      C1US, C1US, 32'(BUS_CYC), 32'(UV_CYC), C5US, C5US, 32'(BUS_CYC),
      32'(F620_CYC), 32'(RECT_CYC)};
   // Modes in which each filter runs
   localparam logic [11:0] FMASK [NCH] = '{
      BFS_MON, M_ALL, BFS_MON, BFS_MON, BFS_MON, BFS_RUN,
      BFS_PU, M_ACT, BFS_RUN, BFS_RUN, BFS_PU, M_ACT, BFS_RUN,
      BFS_RUN, BFS_RUN};
   localparam logic [31:0] L_PU = 32'(PU_CYC - 1);
   localparam logic [31:0] L_SOFT = 32'(SOFT_CYC - 1);
   localparam logic [31:0] L_PH = 32'(PH_CYC - 1);
   localparam logic [31:0] L_IGN_MIN = 32'(IGN_MIN_CYC - 1);
   localparam logic [31:0] L_IGN_MAX = 32'(IGN_MAX_CYC - 1);
   localparam logic [31:0] L_PRE = 32'(PRE_CYC - 1);
   localparam logic [31:0] L_STO = 32'(STO_CYC - 1);
   localparam logic [31:0] L_WF = 32'(WAIT_F_CYC - 1);
   localparam logic [31:0] L_WUV = 32'(WAIT_UV_CYC - 1);
   localparam logic [31:0] L_CLR = 32'(CLR_CYC - 1);

   bfs_comp_t sync1;
   bfs_comp_t sc;
   bfs_state_t state;
   logic [31:0] mode_cnt;
   logic [31:0] wait_len;
   logic [31:0] run_cnt;
   logic [NCH-1:0] raw;
   logic [NCH-1:0] q;
   logic [NCH-1:0] q_d;
   logic cond_sel;
   logic fail_latch;
   logic skip_ph;
   logic [2:0] uv_cnt;
   logic ov_hold;
   logic run_enable;
   logic ev_sto;
   logic ev_ign;
   logic [NEV-1:0] irq_st;
   logic [NEV-1:0] irq_en;
   logic [NEV-1:0] events;
   logic dp_wr;
   logic [7:0] dp_addr;
   logic [31:0] next_rdata;
   logic pu_win;
   logic block;
   logic f_fault;
   logic latch_clr;

   // Two-flop synchroniser for the comparator results
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1 <= '0;
         sc <= '0;
      end else begin
         sync1 <= comp_in;
         sc <= sync1;
      end
   end

   // Power-up checks start only after the bus had time to settle
   assign pu_win = (state == BFS_PU) && (mode_cnt >= CWIN);
   assign raw = {
      sc.lamp_rectifier_effect, sc.lamp_peak_overvoltage,
      sc.boost_bus_above_over, sc.boost_bus_above_over,
      sc.boost_bus_above_high & pu_win,
      sc.boost_bus_below_under, sc.boost_bus_below_open,
      sc.boost_bus_below_open,
      sc.boost_bus_below_open & pu_win,
      sc.ls_filament_sense_high, sc.ls_filament_sense_open,
      sc.hs_filament_sense_b, sc.hs_filament_sense_a,
      sc.supply_below_lockout, sc.supply_below_start};

   // Duration filters; any gap restarts the count
   for (genvar g = 0; g < NCH; g++) begin : g_filt
      logic [31:0] cnt;
      logic act;
      assign act = raw[g] && ((FMASK[g] & state) != 12'h000);
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            cnt <= '0;
         end else if (!act) begin
            cnt <= '0;
         end else if (cnt != FLEN[g]) begin
            cnt <= cnt + 32'h0000_0001;
         end
      end
      assign q[g] = act && (cnt == FLEN[g]);
   end

   assign block = q[0] | sc.supply_below_start | q[2] | q[3] | q[4];
   assign f_fault = q[5] | q[13] | q[14];
   assign latch_clr = (run_cnt == L_CLR) && (state == BFS_RUN);

   // Mode sequencer and fault reactions
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= BFS_MON;
         mode_cnt <= '0;
         wait_len <= '0;
         cond_sel <= 1'b0;
         fail_latch <= 1'b0;
         skip_ph <= 1'b0;
         uv_cnt <= '0;
         ev_sto <= 1'b0;
         ev_ign <= 1'b0;
      end else begin
         mode_cnt <= mode_cnt + 32'h0000_0001;
         ev_sto <= 1'b0;
         ev_ign <= 1'b0;
         if (latch_clr || q[1]) begin
            fail_latch <= 1'b0;
            uv_cnt <= '0;
         end
         if (q[1] && state != BFS_MON) begin
            // Lockout overrides every mode
            state <= BFS_MON;
            mode_cnt <= '0;
            fail_latch <= 1'b0;
            skip_ph <= 1'b0;
            uv_cnt <= '0;
         end else begin
            case (state)
               BFS_MON: begin
                  if (run_enable && !block && !q[1]) begin
                     state <= BFS_PU;
                     mode_cnt <= '0;
                  end
               end
               BFS_PU: begin
                  if (q[6] || q[10]) begin
                     state <= BFS_VWAIT;
                  end else if (mode_cnt == L_PU) begin
                     state <= BFS_SU;
                     mode_cnt <= '0;
                  end
               end
               BFS_SU: begin
                  if (!sc.boost_bus_below_rated) begin
                     state <= BFS_SOFT;
                     mode_cnt <= '0;
                  end else if (mode_cnt == L_STO) begin
                     state <= BFS_RWAIT;
                     wait_len <= L_WF;
                     ev_sto <= 1'b1;
                     mode_cnt <= '0;
                  end
               end
               BFS_SOFT: begin
                  if (mode_cnt == L_SOFT) begin
                     // Emergency restart skips preheating
                     state <= skip_ph ? BFS_IGN : BFS_PH;
                     mode_cnt <= '0;
                  end
               end
               BFS_PH: begin
                  if (preheat_done || mode_cnt == L_PH) begin
                     state <= BFS_IGN;
                     mode_cnt <= '0;
                  end
               end
               BFS_IGN: begin
                  if (ignition_done && mode_cnt >= L_IGN_MIN) begin
                     state <= BFS_PRE;
                     mode_cnt <= '0;
                  end else if (mode_cnt == L_IGN_MAX) begin
                     ev_ign <= 1'b1;
                     mode_cnt <= '0;
                     fail_latch <= 1'b1;
                     wait_len <= L_WF;
                     state <= fail_latch ? BFS_LATCH : BFS_RWAIT;
                  end
               end
               BFS_PRE: begin
                  if (mode_cnt == L_PRE) begin
                     state <= BFS_RUN;
                     skip_ph <= 1'b0;
                     mode_cnt <= '0;
                  end
               end
               BFS_RUN: begin
                  mode_cnt <= '0;
                  if (f_fault) begin
                     fail_latch <= 1'b1;
                     wait_len <= L_WF;
                     state <= fail_latch ? BFS_LATCH : BFS_RWAIT;
                  end else if (q[9]) begin
                     // Past the seventh retry wait for a supply cycle
                     state <= (uv_cnt == UV_MAX) ? BFS_VWAIT : BFS_RWAIT;
                     wait_len <= L_WUV;
                     skip_ph <= 1'b1;
                     if (uv_cnt != UV_MAX) begin
                        uv_cnt <= uv_cnt + 3'h1;
                     end
                  end else if (q[8]) begin
                     state <= BFS_CWAIT;
                     cond_sel <= 1'b0;
                  end else if (q[12]) begin
                     state <= BFS_CWAIT;
                     cond_sel <= 1'b1;
                  end
               end
               BFS_RWAIT: begin
                  if (mode_cnt == wait_len) begin
                     state <= BFS_MON;
                     mode_cnt <= '0;
                  end
               end
               BFS_CWAIT: begin
                  if (cond_sel ? !sc.boost_bus_above_high : !sc.boost_bus_below_open) begin
                     state <= BFS_MON;
                     mode_cnt <= '0;
                  end
               end
               BFS_VWAIT, BFS_LATCH: begin
                  mode_cnt <= '0; // Left only through lockout
               end
               default: begin
                  state <= BFS_MON;
                  mode_cnt <= '0;
               end
            endcase
         end
      end
   end

   // Continuous run time for clearing the fail latch
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         run_cnt <= '0;
      end else if (state != BFS_RUN || latch_clr) begin
         run_cnt <= '0;
      end else begin
         run_cnt <= run_cnt + 32'h0000_0001;
      end
   end

   // PFC overvoltage hold lasts until the bus falls below 105% or the state leaves the active modes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ov_hold <= 1'b0;
      end else if (q[11]) begin
         ov_hold <= 1'b1;
      end else if (!sc.boost_bus_above_high || (state & M_ACT) == 12'h000) begin
         ov_hold <= 1'b0;
      end
   end

   // Drive enables, registered so they never glitch
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gate_enable <= 1'b0;
         pfc_enable <= 1'b0;
      end else begin
         gate_enable <= (state & M_ACT) != 12'h000;
         pfc_enable <= ((state & M_ACT) != 12'h000) && !q[7] && !ov_hold;
      end
   end

   // Interrupt events: qualified faults plus the two mode timeouts
   assign events = {ev_ign, ev_sto, q & ~q_d};

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q_d <= '0;
      end else begin
         q_d <= q;
      end
   end

   // Sticky status; a new event wins over a clear in the same cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_st <= '0;
      end else if (dp_wr && dp_addr == A_IRQ_CLR) begin
         irq_st <= (irq_st & ~hwdata[NEV-1:0]) | events;
      end else begin
         irq_st <= irq_st | events;
      end
   end

   assign irq = (irq_st & irq_en) != '0;

   // AHB-Lite address phase capture
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_wr <= 1'b0;
         dp_addr <= '0;
      end else if (hready) begin
         dp_wr <= hsel && htrans[1] && hwrite;
         dp_addr <= haddr[7:0];
      end
   end

   // Write data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         run_enable <= CTRL_RST[0];
         irq_en <= '0;
      end else if (dp_wr) begin
         if (dp_addr == A_CTRL) begin
            run_enable <= hwdata[0];
         end
         if (dp_addr == A_IRQ_EN) begin
            irq_en <= hwdata[NEV-1:0];
         end
      end
   end

   // Read mux; unmapped and write-only words read zero
   always_comb begin
      next_rdata = '0;
      case (haddr[7:0])
         A_CTRL: next_rdata[0] = run_enable;
         A_STAT: next_rdata = {9'h000, pfc_enable, gate_enable, ov_hold,
                               uv_cnt, skip_ph, fail_latch, 3'h0, state};
         A_IRQ_ST: next_rdata[NEV-1:0] = irq_st;
         A_IRQ_EN: next_rdata[NEV-1:0] = irq_en;
         default: next_rdata = '0;
      endcase
   end

   // Read data registered in the address phase, shown in the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= '0;
      end else if (hready && hsel && htrans[1] && !hwrite) begin
         hrdata <= next_rdata;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
endmodule
`default_nettype wire

// ### tb/bfs_sva.sv
// Purpose: port checker for the ballast fault supervisor
// Assumes: comparator inputs are active high levels
// Notes: counters hold run lengths; sync, filter and output add a few cycles
`timescale 1ns/1ns
`default_nettype none
module bfs_sva
   import bfs_pkg::*;
#(
   parameter longint unsigned PU_CYC = 1100
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire bfs_pkg::bfs_comp_t comp_in,
   input wire logic preheat_done,
   input wire logic ignition_done,
   input wire logic gate_enable,
   input wire logic pfc_enable,
   input wire logic irq
);
   int unsigned c_open, c_over, c_lock, c_start, c_low;
   // Run lengths of inputs and of gates off; never wraps within one run
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         c_open <= 0;
         c_over <= 0;
         c_lock <= 0;
         c_start <= 0;
         c_low <= 0;
      end else begin
         c_open <= comp_in.boost_bus_below_open ? c_open + 1 : 0;
         c_over <= comp_in.boost_bus_above_over ? c_over + 1 : 0;
         c_lock <= comp_in.supply_below_lockout ? c_lock + 1 : 0;
         c_start <= comp_in.supply_below_start ? c_start + 1 : 0;
         c_low <= gate_enable ? 0 : c_low + 1;
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   AST_OKAY: assert property (hreadyout && !hresp)
      else $error("bus answer not ready or not okay");
   AST_UNMAPPED: assert property (hsel && hready && htrans[1] && !hwrite
      && haddr[7:0] > A_IRQ_EN |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   AST_PFC_GATED: assert property (pfc_enable |-> gate_enable)
      else $error("pfc on with gates off");
   AST_OPEN_STOP: assert property (c_open >= 108 |-> !pfc_enable)
      else $error("pfc on during open loop");
   AST_OVER_STOP: assert property (c_over >= 508 |-> !pfc_enable)
      else $error("pfc on during bus overvoltage");
   AST_LOCK_DOWN: assert property (c_lock >= 508 |-> !gate_enable)
      else $error("gates on during supply lockout");
   AST_PU_TIME: assert property ($rose(gate_enable) |-> c_low >= PU_CYC)
      else $error("power-up shorter than its time");
   AST_START_BLOCK: assert property ($rose(gate_enable) |-> c_start < PU_CYC + 110)
      else $error("powered up below start threshold");
   cover property ($rose(irq));
   cover property ($fell(pfc_enable) && gate_enable);
   cover property ($fell(gate_enable));
endmodule
bind bfs_supervisor bfs_sva #(.PU_CYC(PU_CYC)) u_sva (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
   .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .hrdata(hrdata), .comp_in(comp_in), .preheat_done(preheat_done),
   .ignition_done(ignition_done), .gate_enable(gate_enable), .pfc_enable(pfc_enable),
   .irq(irq));
`default_nettype wire

// ### tb/bfs_plant.sv
// Purpose: power stage seen through threshold comparators
// Assumes: levels in mV, nA and per mille of rated bus
// Notes: ideal comparators, no hysteresis
`timescale 1ns/1ns
`default_nettype none
module bfs_plant
   import bfs_pkg::*;
(
   input var int vcc_mv,
   input var int bus_pm,
   input var int ls_mv,
   input var int hsa_na,
   input var int hsb_na,
   input var logic lamp_pk,
   input var logic lamp_dc,
   output var bfs_pkg::bfs_comp_t comp
);
   // Thresholds of each comparator
   always_comb begin
      comp.supply_below_start = vcc_mv < 14100;
      comp.supply_below_lockout = vcc_mv < 10600;
      comp.hs_filament_sense_a = hsa_na < 18000;
      comp.hs_filament_sense_b = hsb_na < 18000;
      comp.ls_filament_sense_open = ls_mv > 1600;
      comp.ls_filament_sense_high = ls_mv > 3200;
      comp.boost_bus_below_open = bus_pm < 125;
      comp.boost_bus_below_under = bus_pm < 750;
      comp.boost_bus_below_rated = bus_pm < 950;
      comp.boost_bus_above_high = bus_pm > 1050;
      comp.boost_bus_above_over = bus_pm > 1090;
      comp.lamp_peak_overvoltage = lamp_pk;
      comp.lamp_rectifier_effect = lamp_dc;
   end
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// Purpose: self-checking bench of the fault supervisor
// Assumes: shortened counts set at the instance
// Notes: state sequence kept in a queue, read back over the bus
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import bfs_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic preheat_done, ignition_done, gate_enable, pfc_enable, irq;
   logic [31:0] haddr, hwdata, hrdata, rd, r;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic lpk, ldc;
   bfs_comp_t comp;
   int vcc, bus, ls, hsa, hsb, num_errors, tests_run;
   bfs_state_t exp_q[$] = '{BFS_PU, BFS_SOFT, BFS_PH, BFS_IGN, BFS_PRE, BFS_RUN};
   assign hready = hreadyout;
   bfs_plant plant (.vcc_mv(vcc), .bus_pm(bus), .ls_mv(ls), .hsa_na(hsa), .hsb_na(hsb),
      .lamp_pk(lpk), .lamp_dc(ldc), .comp(comp));
   // Shortened times for simulation
   localparam longint unsigned FIL_N = 20, F620_N = 30, UV_N = 300, PU_N = 1600;
   localparam longint unsigned SOFT_N = 50, PH_N = 60, IGN_MIN_N = 20, IGN_MAX_N = 80;
   localparam longint unsigned PRE_N = 40, BUS_N = 2000, STO_N = 100, WF_N = 40;
   localparam longint unsigned WUV_N = 30, RECT_N = 70, CLR_N = 2000;
   bfs_supervisor #(.FIL_CYC(FIL_N), .F620_CYC(F620_N), .UV_CYC(UV_N), .PU_CYC(PU_N),
      .SOFT_CYC(SOFT_N), .PH_CYC(PH_N), .IGN_MIN_CYC(IGN_MIN_N), .IGN_MAX_CYC(IGN_MAX_N),
      .PRE_CYC(PRE_N), .BUS_CYC(BUS_N), .STO_CYC(STO_N), .WAIT_F_CYC(WF_N),
      .WAIT_UV_CYC(WUV_N), .RECT_CYC(RECT_N), .CLR_CYC(CLR_N))
      dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .comp_in(comp),
      .preheat_done(preheat_done), .ignition_done(ignition_done),
      .gate_enable(gate_enable), .pfc_enable(pfc_enable), .irq(irq));
   // Clock, 100 MHz
   initial begin
      hclk = 0;
      forever #5 hclk = ~hclk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask
   // One single transfer; read data taken at the data phase edge
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      hsel <= 1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'b10;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      hsel <= 0;
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask
   // Poll the state field until it shows s, bounded
   task automatic wait_st(input bfs_state_t s);
      int n;
      n = 0;
      xfer(A_STAT, 0, 0);
      while (rd[11:0] !== s && n < 3000) begin
         xfer(A_STAT, 0, 0);
         n++;
      end
      chk(rd[11:0], s);
   endtask
   task automatic run_up;
      xfer(A_CTRL, 1, 1);
      foreach (exp_q[i]) wait_st(exp_q[i]);
      chk({gate_enable, pfc_enable}, 2'b11);
   endtask
   task automatic complete_run;
      $display("errors %0d of %0d checks", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Watchdog well beyond the expected run
   initial begin
      #900000;
      num_errors++;
      complete_run;
   end
   initial begin
      {hsel, haddr, htrans, hwrite, hwdata, preheat_done, lpk, ldc} = '0;
      hsize = 3'h2;
      ignition_done = 1;
      vcc = 15000;
      bus = 1000;
      ls = 500;
      hsa = 50000;
      hsb = 50000;
      num_errors = 0;
      tests_run = 0;
      hresetn = 0;
      void'($urandom(58976));
      cyc(3);
      hresetn <= 1;
      cyc(1);
      // Reset values, register access, unmapped place
      xfer(A_CTRL, 0, 0);
      chk(rd, CTRL_RST);
      xfer(A_STAT, 0, 0);
      chk(rd[11:0], BFS_MON);
      chk({gate_enable, pfc_enable, irq}, 3'b000);
      xfer(8'h14, 0, 0);
      chk(rd, 32'h0);
      r = $urandom & 32'h1ffff;
      xfer(A_IRQ_EN, 1, r);
      xfer(A_IRQ_EN, 0, 0);
      chk(rd, r);
      xfer(A_IRQ_EN, 1, 32'h6000);
      xfer(A_IRQ_CLR, 1, 32'h1ffff);
      // Each monitoring fault holds off power-up
      for (int k = 0; k < 4; k++) begin
         vcc <= (k == 0) ? 14000 : 15000;
         hsa <= (k == 1) ? 10000 : 50000;
         hsb <= (k == 2) ? 10000 : 50000;
         ls <= (k == 3) ? 2000 : 500;
         cyc(150);
         xfer(A_CTRL, 1, 1);
         cyc(50);
         xfer(A_STAT, 0, 0);
         chk(rd[11:0], BFS_MON);
         chk(gate_enable, 1'b0);
         xfer(A_CTRL, 1, 0);
      end
      ls <= 500;
      run_up;
      // Single-restart fault, restart, second fault latches
      lpk <= 1;
      cyc(F620_N + 15);
      lpk <= 0;
      xfer(A_STAT, 0, 0);
      chk({gate_enable, rd[15]}, 2'b01);
      chk(irq, 1'b1);
      xfer(A_IRQ_CLR, 1, 32'h2000);
      cyc(1);
      chk(irq, 1'b0);
      run_up;
      ldc <= 1;
      cyc(RECT_N + 15);
      ldc <= 0;
      wait_st(BFS_LATCH);
      chk(irq, 1'b1);
      xfer(A_IRQ_EN, 1, 32'h0);
      cyc(1);
      chk(irq, 1'b0);
      xfer(A_IRQ_ST, 0, 0);
      chk(rd[14], 1'b1);
      // Lockout releases the latch
      vcc <= 10000;
      cyc(520);
      wait_st(BFS_MON);
      chk(rd[15], 1'b0);
      vcc <= 15000;
      // Ignition never reached: timeout is a single-restart fault
      ignition_done <= 0;
      xfer(A_CTRL, 1, 1);
      wait_st(BFS_IGN);
      wait_st(BFS_RWAIT);
      xfer(A_IRQ_ST, 0, 0);
      chk(rd[16], 1'b1);
      ignition_done <= 1;
      run_up;
      // Bus undervoltage restarts without preheat; start-up then times out
      bus <= 700;
      wait_st(BFS_RWAIT);
      chk(rd[19:16], 4'h3);
      wait_st(BFS_SU);
      wait_st(BFS_RWAIT);
      bus <= 1000;
      wait_st(BFS_IGN);
      chk(rd[16], 1'b1);
      wait_st(BFS_RUN);
      // Open loop with a gap, then held
      bus <= 100;
      cyc(60);
      bus <= 1000;
      cyc(1);
      bus <= 100;
      cyc(60);
      chk(pfc_enable, 1'b1);
      cyc(100);
      chk({gate_enable, pfc_enable}, 2'b10);
      bus <= 1000;
      cyc(20);
      chk(pfc_enable, 1'b1);
      // Bus overvoltage holds the switch until below 105 percent
      bus <= 1100;
      cyc(520);
      chk({gate_enable, pfc_enable}, 2'b10);
      bus <= 1070;
      cyc(20);
      chk(pfc_enable, 1'b0);
      bus <= 1000;
      cyc(20);
      chk(pfc_enable, 1'b1);
      complete_run;
   end
endmodule
`default_nettype wire
